/* File: rtl/wake_timer_pkg.sv */
// Constants, field layouts and types shared by the wake-up timer block
package wake_timer_pkg;

  // Datapath widths
  localparam int CNT_W = 41;            // Wake-up counter width
  localparam int ADDR_W = 8;            // APB address width
  localparam int DATA_W = 32;           // APB data width
  localparam int HI_W = CNT_W - DATA_W; // Upper count slice width

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;   // Control
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;   // Status, read clears
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;   // Interrupt mask
  localparam logic [ADDR_W-1:0] OFF_CALREF = 8'h0C; // Reference count
  localparam logic [ADDR_W-1:0] OFF_T0LO = 8'h10;   // Timer 0 low word
  localparam logic [ADDR_W-1:0] OFF_T0HI = 8'h14;   // Timer 0 high, loads
  localparam logic [ADDR_W-1:0] OFF_T1LO = 8'h18;   // Timer 1 low word
  localparam logic [ADDR_W-1:0] OFF_T1HI = 8'h1C;   // Timer 1 high, loads

  // Control field positions
  localparam int CTRL_RUN = 0;    // Two run bits from here
  localparam int CTRL_SOFF = 4;   // Two sleep-disable bits from here
  localparam int CTRL_SEL = 6;    // Two source-select bits from here
  localparam int CTRL_CAL = 8;    // Write one starts calibration

  // Status field positions; mask uses the same layout
  localparam int STAT_RUN = 0;    // Two running bits
  localparam int STAT_EXP = 2;    // Two expired bits
  localparam int STAT_CAL = 4;    // Calibration in progress

  // Reset value of the select field
  localparam logic [1:0] SEL_RST = 2'h0;

  // Calibration figures
  localparam int RC_HZ = 32000;          // Nominal slow clock, Hz
  localparam int REF_HZ = 16000000;      // Reference tick rate, Hz
  localparam int CAL_PERIODS = 20;       // Typical calibration length
  localparam int CAL_EXPECT = REF_HZ / RC_HZ * CAL_PERIODS; // 10000
  localparam int MCLK_NS = 10;           // Block clock period, ns

  // Slow clock sources
  typedef enum logic [1:0] {
    SRC_RC = 2'h0,
    SRC_XTAL = 2'h1,
    SRC_EXT = 2'h2
  } clk_src_t;

  // APB answer sequencer, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ACK = 2'h2
  } apb_st_t;

endpackage

/* File: rtl/wake_counter.sv */
// One 41-bit wake-up down counter with zero-reach pulse
module wake_counter #(
  parameter int W = wake_timer_pkg::CNT_W  // Counter width
) (
  input wire logic mclk,              // Block clock
  input wire logic rstn,              // Async reset, active low
  input wire logic ce,                // Clock enable
  input wire logic step,              // Decrement this cycle
  input wire logic load,              // Load new count
  input wire logic [W-1:0] loadValue, // Count to load
  output logic [W-1:0] count,         // Current count
  output logic zeroHit                // Pulse as count becomes zero
);
  import wake_timer_pkg::*;

  localparam logic [W-1:0] ONE = W'(1); // Decrement step

  typedef struct packed {
    logic [W-1:0] cnt; // Count
    logic hit;         // Zero-reach pulse
  } cnt_st_t;

  cnt_st_t r;
  cnt_st_t n;

  // Next state: load wins, else count down through zero and beyond
  always_comb begin
    n = r;
    n.hit = 1'b0;
    if (load) begin
      n.cnt = loadValue;
    end else if (step) begin
      n.cnt = r.cnt - ONE;
      n.hit = (r.cnt == ONE);
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign count = r.cnt;
  assign zeroHit = r.hit;

  property p_step;
    @(posedge mclk) disable iff (!rstn)
    (ce && step && !load) |=> (count == $past(count) - ONE);
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not decrement by one");

endmodule

/* File: rtl/wakeup_timer.sv */
// Two wake-up timers with RC calibration, APB register slave
module wakeup_timer (
  input wire logic mclk,                                  // 100 MHz clock
  input wire logic rstn,                                  // Async reset
  input wire logic ce,                                    // Clock enable
  input wire logic [wake_timer_pkg::ADDR_W-1:0] paddr,    // APB address
  input wire logic psel,                                  // APB select
  input wire logic penable,                               // APB enable
  input wire logic pwrite,                                // APB write
  input wire logic [wake_timer_pkg::DATA_W-1:0] pwdata,   // APB wdata
  output logic [wake_timer_pkg::DATA_W-1:0] prdata,       // APB rdata
  output logic pready,                                    // APB ready
  output logic pslverr,                                   // APB error
  input wire logic rcClk,                                 // RC 32 kHz pin
  input wire logic xtalClk,                               // XTAL 32 kHz
  input wire logic extClk,                                // Ext 32 kHz
  input wire logic refTick,                               // 16 MHz strobe
  input wire logic sleepMode,                             // Device asleep
  input wire logic deepSleep,                             // Deep sleep
  output logic irq,                                       // Level irq
  output logic wakeEvent                                  // Wake pulse
);
  import wake_timer_pkg::*;

  localparam logic [DATA_W-1:0] REF_ONE = DATA_W'(1); // Reference step

  // Block state in one record, except the two counts held in the timer instances
  typedef struct packed {
    logic [2:0] sync1;          // First synchroniser stage
    logic [2:0] sync2;          // Second synchroniser stage
    logic [2:0] srcPrev;        // Synchronised sources, last cycle
    apb_st_t apbSt;             // Bus answer state
    logic pready;               // Ready output
    logic pslverr;              // Error output
    logic [DATA_W-1:0] prdata;  // Read data output
    logic [1:0] run;            // Run bits
    logic [1:0] sleepOff;       // Stop-in-sleep bits
    clk_src_t clkSel;           // Slow clock source
    logic [1:0] mask;           // Interrupt enables
    logic [1:0] expired;        // Sticky zero-reach flags
    logic [DATA_W-1:0] lo0;     // Timer 0 staged low word
    logic [DATA_W-1:0] lo1;     // Timer 1 staged low word
    logic calBusy;              // Calibration in progress
    logic [DATA_W-1:0] calRef;  // Reference tick count
    logic irq;                  // Interrupt output
    logic wake;                 // Wake pulse output
  } st_t;

  localparam st_t RST = '{apbSt: ST_IDLE, clkSel: clk_src_t'(SEL_RST),
                          default: '0};

  st_t r;
  st_t n;

  logic [CNT_W-1:0] count0;   // Timer 0 count
  logic [CNT_W-1:0] count1;   // Timer 1 count
  logic [1:0] hit;            // Zero-reach pulses
  logic [1:0] adv;            // Decrement enables
  logic [1:0] ldEn;           // Load strobes
  logic [CNT_W-1:0] ldVal;    // Shared load value
  logic [2:0] rise;           // Rising edge of each source
  logic tick;                 // Slow clock rising edge
  logic done;                 // APB completion edge
  logic [DATA_W-1:0] rdVal;   // Read mux
  logic rdHit;                // Address decodes
  logic [1:0] clr;            // Expired bits to clear

  // Counting is allowed when running, awake enough and not deep asleep
  function automatic logic mayCount(input logic run, input logic off);
    mayCount = run && !deepSleep && !(sleepMode && off);
  endfunction

  // Upper slice of a count, zero-extended to a bus word
  function automatic logic [DATA_W-1:0] hiWord(input logic [CNT_W-1:0] c);
    hiWord = DATA_W'(c[CNT_W-1:DATA_W]);
  endfunction

  // Address decode and read mux
  always_comb begin
    rdHit = 1'b1;
    rdVal = '0;
    unique case (paddr)
      OFF_CTRL: begin
        rdVal[CTRL_RUN +: 2] = r.run;
        rdVal[CTRL_SOFF +: 2] = r.sleepOff;
        rdVal[CTRL_SEL +: 2] = r.clkSel;
      end
      OFF_STAT: begin
        rdVal[STAT_RUN +: 2] = r.run;
        rdVal[STAT_EXP +: 2] = r.expired;
        rdVal[STAT_CAL] = r.calBusy;
      end
      OFF_MASK: begin
        rdVal[STAT_EXP +: 2] = r.mask;
      end
      OFF_CALREF: begin
        rdVal = r.calRef;
      end
      OFF_T0LO: begin
        rdVal = count0[DATA_W-1:0];
      end
      OFF_T0HI: begin
        rdVal = hiWord(count0);
      end
      OFF_T1LO: begin
        rdVal = count1[DATA_W-1:0];
      end
      OFF_T1HI: begin
        rdVal = hiWord(count1);
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    n = r;
    ldEn = '0;
    ldVal = '0;
    clr = '0;
    // Pins pass two flops; only sync2 is looked at
    n.sync1 = {extClk, xtalClk, rcClk};
    n.sync2 = r.sync1;
    // Edges are found per source before the select, so switching
    // sources never pairs two different levels into a false edge
    n.srcPrev = r.sync2;
    rise = r.sync2 & ~r.srcPrev;
    unique case (r.clkSel)
      SRC_XTAL: tick = rise[1];
      SRC_EXT: tick = rise[2];
      default: tick = rise[0];
    endcase
    adv[0] = tick && mayCount(r.run[0], r.sleepOff[0]);
    adv[1] = tick && mayCount(r.run[1], r.sleepOff[1]);
    done = psel && penable && r.pready;
    // Bus answer: one wait state, then ready for one cycle
    unique case (r.apbSt)
      ST_IDLE: begin
        if (psel && penable) begin
          n.apbSt = ST_ACK;
          n.pready = 1'b1;
          n.prdata = pwrite ? '0 : rdVal;
          n.pslverr = !rdHit;
        end
      end
      ST_ACK: begin
        n.apbSt = ST_IDLE;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.prdata = '0;
      end
    endcase
    // Writes take effect at the completion edge
    if (done && pwrite) begin
      unique case (paddr)
        OFF_CTRL: begin
          n.run = pwdata[CTRL_RUN +: 2];
          n.sleepOff = pwdata[CTRL_SOFF +: 2];
          n.clkSel = clk_src_t'(pwdata[CTRL_SEL +: 2]);
        end
        OFF_MASK: n.mask = pwdata[STAT_EXP +: 2];
        OFF_T0LO: n.lo0 = pwdata;
        OFF_T1LO: n.lo1 = pwdata;
        OFF_T0HI: begin
          ldEn[0] = 1'b1;
          ldVal = {pwdata[HI_W-1:0], r.lo0};
        end
        OFF_T1HI: begin
          ldEn[1] = 1'b1;
          ldVal = {pwdata[HI_W-1:0], r.lo1};
        end
        default: ;
      endcase
    end
    // Clear only the flags the captured read data showed, so an
    // expiry landing between capture and completion is kept
    if (done && !pwrite && paddr == OFF_STAT) begin
      clr = r.prdata[STAT_EXP +: 2];
    end
    n.expired = (r.expired & ~clr) | hit;
    // Calibration: reference counts while timer 0 runs down
    if (done && pwrite && paddr == OFF_CTRL && pwdata[CTRL_CAL]) begin
      n.calBusy = 1'b1;
      n.calRef = '0;
    end else if (r.calBusy) begin
      if (hit[0]) begin
        n.calBusy = 1'b0;
      end else if (refTick && r.run[0]) begin
        n.calRef = r.calRef + REF_ONE;
      end
    end
    // Stopped timers raise no interrupt even with a stale flag
    n.irq = |(n.expired & n.mask & n.run);
    n.wake = sleepMode && |(hit & r.mask);
  end

  // State register, frozen while ce is low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r <= RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // Timer 0, also the calibration window
  wake_counter #(.W(CNT_W)) uTimer0 (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .step(adv[0]),
    .load(ldEn[0]),
    .loadValue(ldVal),
    .count(count0),
    .zeroHit(hit[0])
  );

  // Timer 1
  wake_counter #(.W(CNT_W)) uTimer1 (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .step(adv[1]),
    .load(ldEn[1]),
    .loadValue(ldVal),
    .count(count1),
    .zeroHit(hit[1])
  );

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign wakeEvent = r.wake;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_ready;
    ce && psel && penable && !pready ##1 ce |-> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("bus answer missing after one wait cycle");

  property p_expire;
    ce && hit[0] && !ldEn[0] |=> r.expired[0];
  endproperty
  a_expire: assert property (p_expire)
    else $error("expired flag not set at zero");

  property p_hold;
    ce && !r.run[1] && !ldEn[1] |=> $stable(count1);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stopped timer changed its count");

  property p_deep;
    deepSleep && !ldEn[0] |=> $stable(count0);
  endproperty
  a_deep: assert property (p_deep)
    else $error("timer counted in deep sleep");

  property p_noirq;
    irq |-> (r.expired & r.mask & r.run) != 2'h0;
  endproperty
  a_noirq: assert property (p_noirq)
    else $error("interrupt while both timers stopped");

  property p_clear;
    ce && done && !pwrite && paddr == OFF_STAT && r.prdata[STAT_EXP]
      && !hit[0] |=> !r.expired[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("status read did not clear expired flag");

  property p_calstop;
    ce && r.calBusy && hit[0] ##1 ce |-> !r.calBusy ##1 $stable(r.calRef);
  endproperty
  a_calstop: assert property (p_calstop)
    else $error("reference counter not stopped at zero");

  property p_calrun;
    ce && r.calBusy && !hit[0] && refTick && r.run[0] && !done
      |=> r.calRef == $past(r.calRef) + REF_ONE;
  endproperty
  a_calrun: assert property (p_calrun)
    else $error("reference counter missed a tick");

  property p_wake;
    wakeEvent |-> $past(sleepMode) && $past(hit) != 2'h0;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse without sleeping expiry");

  property p_sleepoff;
    ce && sleepMode && r.sleepOff[0] && !ldEn[0] |=> $stable(count0);
  endproperty
  a_sleepoff: assert property (p_sleepoff)
    else $error("timer counted in sleep while disabled for sleep");

  property p_status;
    ce && done && !pwrite && paddr == OFF_STAT
      |-> prdata[STAT_RUN +: 2] == r.run;
  endproperty
  a_status: assert property (p_status)
    else $error("status read returned wrong running bits");

endmodule

/* File: bench/wakeup_timer_tb.sv */
// Self-checking bench for the two wake-up timers and calibration counter
module wakeup_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wake_timer_pkg::*;

  // Slow source periods in mclk cycles; RC matches the nominal ratio
  localparam int RC_CYC = CAL_EXPECT / CAL_PERIODS;
  localparam int XT_CYC = RC_CYC * 9 / 10; // Faster source
  localparam int EX_CYC = RC_CYC * 11 / 10; // Slower source

  logic mclk = 1'b0; // Block clock
  logic rstn = 1'b0; // Reset, active low
  logic ce = 1'b1; // Clock enable, high except in the freeze test
  logic [ADDR_W-1:0] paddr = '0; // APB address
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB enable
  logic pwrite = 1'b0; // APB direction
  logic [DATA_W-1:0] pwdata = '0; // APB write data
  logic [DATA_W-1:0] prdata; // APB read data
  logic pready; // APB ready
  logic pslverr; // APB error
  logic rcClk = 1'b0; // RC source
  logic xtalClk = 1'b0; // Crystal source
  logic extClk = 1'b0; // External source
  logic refTick = 1'b1; // Reference strobe, every cycle
  logic sleepMode = 1'b0; // Asleep
  logic deepSleep = 1'b0; // Deep sleep
  logic irq; // Level interrupt
  logic wakeEvent; // Wake pulse
  int err_total = 0; // Mismatch count
  int n_tests = 0; // Comparison count
  int seed = 32'h1b16e447; // Fixed random seed
  int wakeCnt = 0; // Wake pulses seen
  logic [DATA_W-1:0] rd; // Last read data
  logic serr; // Last error response

  wakeup_timer dut (.mclk(mclk), .rstn(rstn), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rcClk(rcClk),
    .xtalClk(xtalClk), .extClk(extClk), .refTick(refTick),
    .sleepMode(sleepMode), .deepSleep(deepSleep), .irq(irq),
    .wakeEvent(wakeEvent));

  // Clocks; slow sources use odd phases against mclk
  always #5 mclk = ~mclk;
  always #(RC_CYC * MCLK_NS / 2) rcClk = ~rcClk;
  always #(XT_CYC * MCLK_NS / 2) xtalClk = ~xtalClk;
  always #(EX_CYC * MCLK_NS / 2) extClk = ~extClk;

  // Count one-cycle wake pulses as they stand
  always @(posedge mclk) begin
    if (wakeEvent === 1'b1) begin
      wakeCnt++;
    end
  end

  // Compare and report
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 100) begin
      err_total++;
    end
  endtask

  // Timer load is LO then HI; HI commits the whole count
  task automatic loadT(input int t, input logic [CNT_W-1:0] v);
    apb(1'b1, t ? OFF_T1LO : OFF_T0LO, v[DATA_W-1:0]);
    apb(1'b1, t ? OFF_T1HI : OFF_T0HI, DATA_W'(v[CNT_W-1:DATA_W]));
  endtask

  // Count read is not atomic, so only used while the timer is still
  task automatic readCnt(input int t, output logic [63:0] v);
    apb(1'b0, t ? OFF_T1LO : OFF_T0LO, '0);
    v[31:0] = rd;
    apb(1'b0, t ? OFF_T1HI : OFF_T0HI, '0);
    v[63:32] = 32'(rd[HI_W-1:0]);
  endtask

  function automatic logic [DATA_W-1:0] ctrlOf(input logic [1:0] run,
      input logic [1:0] soff, input logic [1:0] sel, input logic cal);
    ctrlOf = '0;
    ctrlOf[CTRL_RUN+:2] = run;
    ctrlOf[CTRL_SOFF+:2] = soff;
    ctrlOf[CTRL_SEL+:2] = sel;
    ctrlOf[CTRL_CAL] = cal;
  endfunction

  function automatic logic [DATA_W-1:0] statOf(input logic [1:0] run,
      input logic [1:0] expd, input logic cal);
    statOf = '0;
    statOf[STAT_RUN+:2] = run;
    statOf[STAT_EXP+:2] = expd;
    statOf[STAT_CAL] = cal;
  endfunction

  // Watchdog well beyond the expected run length
  initial begin
    waitCyc(90000);
    err_total++;
    final_report();
  end

  // Main sequence
  initial begin
    logic [ADDR_W-1:0] regs[5];
    logic [63:0] c;
    logic [63:0] c2;
    logic [CNT_W-1:0] v;
    int per;
    int k;
    regs = '{OFF_CTRL, OFF_STAT, OFF_MASK, OFF_CALREF, OFF_T1HI};
    waitCyc(8);
    rstn <= 1'b1;
    // Reset values of registers and interrupt
    foreach (regs[i]) begin
      apb(1'b0, regs[i], '0);
      check({serr, rd}, '0);
    end
    check(irq, 1'b0);
    // Unmapped place: error answer, zero data
    apb(1'b1, 8'h20, $random(seed));
    check(serr, 1'b1);
    apb(1'b0, 8'h20, '0);
    check({serr, rd}, {1'b1, 32'h0});
    // Stopped timer 1 keeps any 41-bit count, all-ones corner first
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? '1 : CNT_W'({$random(seed), $random(seed)});
      loadT(1, v);
      waitCyc(RC_CYC * 2);
      readCnt(1, c);
      check(c, 64'(v));
    end
    // Expiry with interrupt enabled before the load
    apb(1'b1, OFF_MASK, statOf(2'b00, 2'b01, 1'b0));
    loadT(0, CNT_W'(2));
    apb(1'b1, OFF_CTRL, ctrlOf(2'b01, 2'b00, SRC_RC, 1'b0));
    k = 0;
    while (irq !== 1'b1 && k < RC_CYC * 4) begin
      waitCyc(1);
      k++;
    end
    check(irq, 1'b1);
    apb(1'b0, OFF_STAT, '0);
    check(rd, statOf(2'b01, 2'b01, 1'b0));
    apb(1'b0, OFF_STAT, '0);
    check(rd, statOf(2'b01, 2'b00, 1'b0));
    check(irq, 1'b0);
    // Count wraps below zero and keeps going
    waitCyc(RC_CYC + 8);
    apb(1'b0, OFF_T0HI, '0);
    check(rd[HI_W-1:0], {HI_W{1'b1}});
    apb(1'b1, OFF_CTRL, '0);
    readCnt(0, c);
    waitCyc(RC_CYC * 2);
    readCnt(0, c2);
    check(c2, c);
    check(irq, 1'b0);
    // Clock enable low freezes a running timer; the few enabled
    // cycles around the freeze allow one decrement at the most
    apb(1'b1, OFF_CTRL, ctrlOf(2'b01, 2'b00, SRC_RC, 1'b0));
    ce <= 1'b0;
    waitCyc(RC_CYC * 2);
    ce <= 1'b1;
    apb(1'b1, OFF_CTRL, '0);
    readCnt(0, c2);
    check(c - c2 <= 64'h1, 1'b1);
    // Masked expiry still flags, no interrupt
    apb(1'b1, OFF_MASK, '0);
    loadT(1, CNT_W'(1));
    apb(1'b1, OFF_CTRL, ctrlOf(2'b10, 2'b00, SRC_RC, 1'b0));
    waitCyc(RC_CYC * 2 + 8);
    check(irq, 1'b0);
    apb(1'b0, OFF_STAT, '0);
    check(rd, statOf(2'b10, 2'b10, 1'b0));
    // Sleep freeze when disabled for sleep, deep sleep freeze
    apb(1'b1, OFF_CTRL, '0);
    apb(1'b1, OFF_MASK, statOf(2'b00, 2'b01, 1'b0));
    loadT(0, CNT_W'(3));
    sleepMode <= 1'b1;
    apb(1'b1, OFF_CTRL, ctrlOf(2'b01, 2'b01, SRC_RC, 1'b0));
    readCnt(0, c);
    waitCyc(RC_CYC * 2);
    readCnt(0, c2);
    check(c2, c);
    deepSleep <= 1'b1;
    apb(1'b1, OFF_CTRL, ctrlOf(2'b01, 2'b00, SRC_RC, 1'b0));
    waitCyc(RC_CYC * 2);
    readCnt(0, c2);
    check(c2, c);
    // Ordinary sleep: count runs out and wakes the device
    wakeCnt = 0;
    deepSleep <= 1'b0;
    waitCyc(RC_CYC * 5);
    check(wakeCnt, 1);
    apb(1'b1, OFF_CTRL, '0);
    sleepMode <= 1'b0;
    apb(1'b0, OFF_STAT, '0);
    // Calibration on each source: nominal, faster and slower
    for (int s = 0; s < 3; s++) begin
      per = (s == 0) ? RC_CYC : ((s == 1) ? XT_CYC : EX_CYC);
      loadT(0, CNT_W'(CAL_PERIODS));
      apb(1'b1, OFF_CTRL, ctrlOf(2'b01, 2'b00, 2'(s), 1'b1));
      k = 0;
      do begin
        waitCyc(RC_CYC);
        apb(1'b0, OFF_STAT, '0);
        k++;
      end while (rd[STAT_CAL] !== 1'b0 && k < 30);
      check(rd[STAT_CAL], 1'b0);
      apb(1'b0, OFF_CALREF, '0);
      c = 64'(rd);
      // One slow period of phase slack between start and first edge
      check((c + 64'(per) >= 64'(CAL_PERIODS * per)) &&
            (c <= 64'(CAL_PERIODS * per + 8)), 1'b1);
      waitCyc(RC_CYC * 2);
      apb(1'b0, OFF_CALREF, '0);
      check(64'(rd), c);
      apb(1'b1, OFF_CTRL, '0);
    end
    final_report();
  end
endmodule
